// ===== tb/fl_host_model.sv
`timescale 1ns/100ps
module fl_host_model
    import fl_pkg::*;
(
    input  wire logic       mclk,
    output fl_reg_req_t     reg_req,
    input  wire logic [7:0] reg_rdata
);
    initial reg_req = '0;
    // One-cycle strobe; released address and data turn inverse so stale values never look valid.
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge mclk);
        reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(negedge mclk);
        q = reg_rdata;
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic arm(input logic [7:0] m, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b1, 1'b0, FL_OFS_LED_ENABLE, e, q);
        acc(1'b1, 1'b0, FL_OFS_MODE_CTL, m, q);
    endtask
endmodule

// ===== tb/fl_mode_monitor.sv
`timescale 1ns/100ps
module fl_mode_monitor
    import fl_pkg::*;
#(
    parameter int unsigned FLASH_STEP_CYCLES = FL_FLASH_STEP_CYCLES
) (
    input wire logic          mclk,
    input wire logic          reset_n,
    input wire logic          clk_en,
    input wire logic          en_pin,
    input wire logic          strobe_pin,
    input wire logic          torch_pin,
    input wire logic          headroom_short,
    input wire logic          headroom_surplus,
    input wire fl_reg_req_t   reg_req,
    input wire logic [7:0]    reg_rdata,
    input wire fl_led_drive_t led1_drive,
    input wire fl_led_drive_t led2_drive,
    input wire logic          boost_on,
    input wire logic          pass_through,
    input wire logic          vout_5v_reg,
    input wire logic          standby,
    input wire logic          flash_active
);
    localparam int unsigned MAX_CYC = 16 * FLASH_STEP_CYCLES;
    int unsigned run_r;
    wire take_w = clk_en && en_pin && reg_req.wr && reg_req.addr == FL_OFS_MODE_CTL;
    wire [2:0] code_w = reg_req.wdata[2:0];
    wire any_on_w = led1_drive.on || led2_drive.on;
    wire surplus_w = headroom_surplus && !headroom_short && !vout_5v_reg && clk_en;
    wire dark_ok_w = (led1_drive.on || led1_drive.level == 8'h00) && (led2_drive.on || led2_drive.level == 8'h00);
    wire rd_gap_w = clk_en && en_pin && reg_req.rd && reg_req.addr == 8'h03;
    // A frozen clock enable holds the flash, so only enabled cycles count.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            run_r <= 0;
        else
            run_r <= flash_active ? run_r + 32'(clk_en) : 0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_standby_write: assert property (take_w && code_w == 3'h0 |=> standby)
        else $error("standby missing after mode 000 write");
    a_vout_write: assert property (take_w && (code_w == 3'h1 || code_w == 3'h6) |=> vout_5v_reg)
        else $error("fixed output missing after 5V mode write");
    a_assist_write: assert property (take_w && code_w == 3'h2 |=> !vout_5v_reg && !standby)
        else $error("mode 010 decoded wrongly");
    a_flash_bound: assert property (run_r <= MAX_CYC)
        else $error("flash longer than the longest duration");
    a_boost_fixed: assert property ($past(vout_5v_reg && en_pin && clk_en) |-> boost_on)
        else $error("boost off in fixed output mode");
    a_boost_surplus: assert property ($past(surplus_w) |-> !boost_on)
        else $error("boost on despite surplus headroom");
    a_pass_excl: assert property (pass_through |-> !boost_on && any_on_w)
        else $error("pass through without load or with boost");
    a_dark_level: assert property (dark_ok_w)
        else $error("current level on a dark output");
    a_en_low_dark: assert property ($past(!en_pin && clk_en) |-> !any_on_w && standby && !flash_active)
        else $error("activity while the device is disabled");
    a_unmapped_zero: assert property (rd_gap_w |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_flash: cover property ($rose(flash_active));
    c_vout: cover property (vout_5v_reg);
    c_pass: cover property (pass_through);
endmodule

bind fl_mode_ctrl fl_mode_monitor #(.FLASH_STEP_CYCLES(FLASH_STEP_CYCLES)) u_mon (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .en_pin(en_pin), .strobe_pin(strobe_pin),
    .torch_pin(torch_pin), .headroom_short(headroom_short), .headroom_surplus(headroom_surplus),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .led1_drive(led1_drive), .led2_drive(led2_drive),
    .boost_on(boost_on), .pass_through(pass_through), .vout_5v_reg(vout_5v_reg), .standby(standby),
    .flash_active(flash_active));

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import fl_pkg::*;
;
    localparam int STEP = 4;
    logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, en_pin = 1'b1, strobe_pin = 1'b0, torch_pin = 1'b0;
    logic hs_short = 1'b0, hs_surplus = 1'b0, boost_on, pass_through, vout_5v_reg, standby, flash_active;
    fl_reg_req_t   reg_req;
    logic [7:0]    reg_rdata, q;
    fl_led_drive_t led1_drive, led2_drive;
    int            miscompares = 0, checks_done = 0, len;
    logic [7:0] ofs [9] = '{8'h01, 8'h02, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0f, 8'h03};
    logic [7:0] rstv [9] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mskv [9] = '{8'h3f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h03, 8'h00};
    always #12.5 mclk = ~mclk;
    fl_mode_ctrl #(.FLASH_STEP_CYCLES(STEP)) dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .en_pin(en_pin), .strobe_pin(strobe_pin), .torch_pin(torch_pin), .headroom_short(hs_short),
        .headroom_surplus(hs_surplus), .reg_req(reg_req), .reg_rdata(reg_rdata), .led1_drive(led1_drive),
        .led2_drive(led2_drive), .boost_on(boost_on), .pass_through(pass_through),
        .vout_5v_reg(vout_5v_reg), .standby(standby), .flash_active(flash_active));
    fl_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.acc(1'b1, 1'b0, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.acc(1'b0, 1'b1, a, 8'h00, q);
        chk({1'b0, q}, {1'b0, e});
    endtask
    // Flash length in cycles, counted on settled falling edges.
    task automatic meas(output int n);
        n = 0;
        for (int i = 0; i < 40 && flash_active !== 1'b1; i++) @(negedge mclk);
        while (flash_active === 1'b1 && n < 100) begin
            n++;
            @(negedge mclk);
        end
    endtask
    task automatic give_verdict;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(25 * 5000);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        chk({8'h00, standby}, 9'h001);
        for (int i = 0; i < 9; i++) begin
            rdc(ofs[i], rstv[i]);
            wr(ofs[i], 8'hff);
            rdc(ofs[i], mskv[i]);
        end
        wr(8'h01, 8'h00);
        wr(8'h0f, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h01, 8'(c));
            @(negedge mclk);
            chk({8'h00, standby}, {8'h00, c == 0});
            chk({8'h00, vout_5v_reg}, {8'h00, c == 1 || c == 6});
            if (c == 1 || c == 6) chk({8'h00, boost_on}, 9'h001);
        end
        wr(8'h01, 8'h00);
        wr(8'h08, 8'h21);
        wr(8'h0b, 8'h42);
        wr(8'h06, 8'h11);
        wr(8'h09, 8'h22);
        wr(8'h02, 8'h01);
        host.arm(8'h02, 8'h01);
        repeat (2) @(negedge mclk);
        chk(led1_drive, {1'b1, 8'h21});
        chk(led2_drive, 9'h000);
        wr(8'h0f, 8'h03);
        repeat (2) @(negedge mclk);
        chk(led2_drive, {1'b1, 8'h42});
        hs_surplus = 1'b1;
        repeat (2) @(negedge mclk);
        chk({7'h00, pass_through, boost_on}, 9'h002);
        hs_surplus = 1'b0;
        hs_short = 1'b1;
        repeat (2) @(negedge mclk);
        chk({8'h00, boost_on}, 9'h001);
        hs_short = 1'b0;
        wr(8'h0f, 8'h00);
        repeat (2) @(negedge mclk);
        chk(led1_drive, 9'h000);
        wr(8'h0f, 8'h01);
        wr(8'h01, 8'h00);
        repeat (2) @(negedge mclk);
        chk(led1_drive, 9'h000);
        host.arm(8'h03, 8'h02);
        fork
            meas(len);
            begin
                repeat (3) @(negedge mclk);
                chk(led2_drive, {1'b1, 8'h22});
                chk(led1_drive, 9'h000);
                clk_en = 1'b0;
                repeat (3) @(negedge mclk);
                clk_en = 1'b1;
            end
        join
        chk(9'(len), 9'(2 * STEP + 3));
        rdc(8'h01, 8'h00);
        rdc(8'h0f, 8'h00);
        wr(8'h02, 8'h00);
        host.arm(8'h0b, 8'h01);
        strobe_pin = 1'b1;
        meas(len);
        chk(9'(len), 9'(STEP));
        strobe_pin = 1'b0;
        rdc(8'h0c, 8'h10);
        rdc(8'h0c, 8'h00);
        wr(8'h02, 8'h03);
        host.arm(8'h0b, 8'h01);
        strobe_pin = 1'b1;
        fork
            meas(len);
            begin
                repeat (6) @(negedge mclk);
                strobe_pin = 1'b0;
            end
        join
        chk({8'h00, len >= 4 && len < 4 * STEP}, 9'h001);
        rdc(8'h0c, 8'h00);
        strobe_pin = 1'b1;
        wr(8'h02, 8'h01);
        host.arm(8'h3b, 8'h01);
        repeat (5) @(negedge mclk);
        chk({8'h00, flash_active}, 9'h000);
        strobe_pin = 1'b0;
        fork
            meas(len);
            begin
                repeat (2) @(negedge mclk);
                strobe_pin = 1'b1;
            end
        join
        chk(9'(len), 9'(2 * STEP));
        rdc(8'h0c, 8'h00);
        strobe_pin = 1'b0;
        wr(8'h02, 8'h00);
        host.arm(8'h04, 8'h03);
        torch_pin = 1'b1;
        repeat (2) @(negedge mclk);
        chk(led2_drive, {1'b1, 8'h22});
        repeat (8) @(negedge mclk);
        torch_pin = 1'b0;
        rdc(8'h01, 8'h00);
        host.arm(8'h05, 8'h03);
        torch_pin = 1'b1;
        repeat (12) @(negedge mclk);
        chk(led2_drive, {1'b1, 8'h22});
        torch_pin = 1'b0;
        rdc(8'h01, 8'h05);
        host.arm(8'h02, 8'h01);
        en_pin = 1'b0;
        repeat (2) @(negedge mclk);
        chk(led1_drive, 9'h000);
        wr(8'h01, 8'h02);
        en_pin = 1'b1;
        rdc(8'h01, 8'h00);
        give_verdict();
    end
endmodule

// ===== verilog/fl_flash_timer.sv
`timescale 1ns/100ps
module fl_flash_timer
    import fl_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = FL_FLASH_STEP_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [3:0] limit,
    output logic            expired
);

    logic [31:0] pre_r;
    logic [3:0]  step_r;
    logic        step_end;

    assign step_end = (pre_r == 32'(STEP_CYCLES - 1));
    // Pulses in the last cycle of step number limit, so the on-time is exactly (limit + 1) steps.
    assign expired  = run && step_end && (step_r == limit);

    // Time only accumulates while run is high; a pause keeps the count, which gives
    // the combined on-time of both outputs in the independent timed mode.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pre_r  <= 32'h0;
            step_r <= 4'h0;
        end else if (clk_en) begin
            if (clear || expired) begin
                pre_r  <= 32'h0;
                step_r <= 4'h0;
            end else if (run) begin
                pre_r  <= step_end ? 32'h0 : pre_r + 32'h1;
                step_r <= step_end ? step_r + 4'h1 : step_r;
            end
        end
    end

endmodule

// ===== verilog/fl_mode_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - Three-bit mode field, seven modes, 111 reserved
// - Register writes accepted only while enable high
// - Code 000 is standby and reset value
// - 001 fixed 5V; 110 5V plus torch
// - 100 independent timed; 101 independent untimed
// - Boost on low headroom, pass-through on surplus
// - Assist drives continuous assist levels per LED
// - Assist stops on standby or both disabled
// - Flash drives LED1 and LED2 flash levels
// - Flash length limited by four-bit timer field
// - Disabled LED gets no flash current
// - Source bit: 0 software, 1 strobe pin
// - Hardware mode: active strobe starts flash
// - Level mode: on while strobe, timer bounded
// - Level strobe past duration: end, set timeout flag
// - Edge mode: rising edge, exact timer duration
// - Polarity bit inverts strobe to active low
// - Each LED has its own current codes
module fl_mode_ctrl
    import fl_pkg::*;
#(
    parameter int unsigned FLASH_STEP_CYCLES = FL_FLASH_STEP_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic          en_pin,
    input  wire logic          strobe_pin,
    input  wire logic          torch_pin,
    input  wire logic          headroom_short,
    input  wire logic          headroom_surplus,
    input  wire fl_reg_req_t   reg_req,
    output logic [7:0]         reg_rdata,
    output fl_led_drive_t      led1_drive,
    output fl_led_drive_t      led2_drive,
    output logic               boost_on,
    output logic               pass_through,
    output logic               vout_5v_reg,
    output logic               standby,
    output logic               flash_active
);

    logic [7:0]    mode_ctl_r;
    logic [7:0]    mode_ctl_nxt;
    logic [7:0]    timer_r;
    logic [7:0]    timer_nxt;
    logic [7:0]    led1_flash_r;
    logic [7:0]    led1_flash_nxt;
    logic [7:0]    led1_assist_r;
    logic [7:0]    led1_assist_nxt;
    logic [7:0]    led2_flash_r;
    logic [7:0]    led2_flash_nxt;
    logic [7:0]    led2_assist_r;
    logic [7:0]    led2_assist_nxt;
    logic [7:0]    fault_r;
    logic [7:0]    fault_nxt;
    logic [7:0]    enable_r;
    logic [7:0]    enable_nxt;
    logic [7:0]    rdata_nxt;
    logic          strobe_prev_r;
    logic          boost_r;
    logic          boost_nxt;
    fl_state_t     state_r;
    fl_state_t     state_nxt;
    fl_led_drive_t led1_r;
    fl_led_drive_t led1_nxt;
    fl_led_drive_t led2_r;
    fl_led_drive_t led2_nxt;

    // An address match that is only honoured while the enable pin is high.
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction

    // Selects the current code that reaches an LED, or nothing when its enable is clear.
    function automatic fl_led_drive_t led_pick(input logic en, input logic on, input logic [7:0] level);
        fl_led_drive_t pick;
        pick.on    = en && on;
        pick.level = pick.on ? level : 8'h00;
        return pick;
    endfunction

    wire        wr_ok      = reg_req.wr && en_pin;
    wire        wr_mode    = reg_hit(wr_ok, reg_req.addr, FL_OFS_MODE_CTL);
    wire        wr_timer   = reg_hit(wr_ok, reg_req.addr, FL_OFS_TIMER);
    wire        wr_l1f     = reg_hit(wr_ok, reg_req.addr, FL_OFS_LED1_FLASH);
    wire        wr_l1a     = reg_hit(wr_ok, reg_req.addr, FL_OFS_LED1_ASSIST);
    wire        wr_l2f     = reg_hit(wr_ok, reg_req.addr, FL_OFS_LED2_FLASH);
    wire        wr_l2a     = reg_hit(wr_ok, reg_req.addr, FL_OFS_LED2_ASSIST);
    wire        wr_enable  = reg_hit(wr_ok, reg_req.addr, FL_OFS_LED_ENABLE);
    wire        rd_ok      = reg_req.rd && en_pin;
    wire        rd_fault   = reg_hit(rd_ok, reg_req.addr, FL_OFS_FAULT);

    wire [2:0]  operating_mode_field     = mode_ctl_r[FL_MODE_MSB:FL_MODE_LSB];
    wire        trigger_source_select    = mode_ctl_r[FL_TRIG_SRC_BIT];
    wire        trigger_polarity_select  = mode_ctl_r[FL_TRIG_POL_BIT];
    wire        trigger_edge_select      = mode_ctl_r[FL_TRIG_EDGE_BIT];
    wire [3:0]  flash_duration_field     = timer_r[FL_TIMER_MSB:FL_TIMER_LSB];
    wire        first_led_enable         = enable_r[FL_FIRST_LED_ENABLE_BIT];
    wire        second_led_enable        = enable_r[FL_SECOND_LED_ENABLE_BIT];
    wire        any_en                   = first_led_enable || second_led_enable;

    wire        m_flash    = (operating_mode_field == FL_MODE_FLASH);
    wire        m_assist   = (operating_mode_field == FL_MODE_ASSIST);
    wire        m_torch5v  = (operating_mode_field == FL_MODE_TORCH5V);
    wire        m_fixed5v  = (operating_mode_field == FL_MODE_FIXED5V);
    wire        m_indep_to = (operating_mode_field == FL_MODE_INDEP_TO);
    wire        m_indep    = m_indep_to || (operating_mode_field == FL_MODE_INDEP);

    // The previous level is taken every enabled cycle, so a strobe already active when the
    // edge trigger is armed is not an edge and must be released first.
    wire        strobe_act  = strobe_pin ^ trigger_polarity_select;
    wire        strobe_rise = strobe_act && !strobe_prev_r;
    wire        hw_level    = trigger_source_select && !trigger_edge_select;
    wire        hw_edge     = trigger_source_select && trigger_edge_select;

    // The flash ends when its mode or both enables are withdrawn by the host.
    wire        flash_abort = (state_r != FL_ST_IDLE) && (!m_flash || !any_en);

    wire        indep_on1   = m_indep && first_led_enable && strobe_act;
    wire        indep_on2   = m_indep && second_led_enable && torch_pin;
    wire        tmr_run     = (state_r == FL_ST_FLASH && !flash_abort)
                              || (m_indep_to && (indep_on1 || indep_on2));
    // Idle and armed states clear the timer so each flash gets its full duration; the
    // independent timed mode keeps its count across pauses instead.
    wire        tmr_clear   = !((state_r == FL_ST_FLASH) || m_indep_to);
    logic       tmr_expired;

    fl_flash_timer #(
        .STEP_CYCLES (FLASH_STEP_CYCLES)
    ) u_timer (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .clear   (tmr_clear),
        .run     (tmr_run),
        .limit   (flash_duration_field),
        .expired (tmr_expired)
    );

    wire        in_flash      = (state_r == FL_ST_FLASH) && !flash_abort;
    wire        flash_timeout = in_flash && tmr_expired;
    wire        level_release = in_flash && hw_level && !strobe_act;
    // A strobe released in the timeout cycle itself ends the flash without a fault.
    wire        timeout_fault = flash_timeout && hw_level && strobe_act;
    wire        indep_timeout = m_indep_to && tmr_expired;
    wire        hw_standby    = flash_timeout || level_release || indep_timeout;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FL_ST_IDLE: begin
                if (m_flash && any_en) begin
                    state_nxt = trigger_source_select ? FL_ST_ARMED : FL_ST_FLASH;
                end
            end
            // Rewriting the mode while armed keeps the arming; only a withdrawn mode or enables disarm.
            FL_ST_ARMED: begin
                if (flash_abort) begin
                    state_nxt = FL_ST_IDLE;
                end else if ((hw_edge && strobe_rise) || (!hw_edge && strobe_act)) begin
                    state_nxt = FL_ST_FLASH;
                end
            end
            FL_ST_FLASH: begin
                if (flash_abort || flash_timeout || level_release) begin
                    state_nxt = FL_ST_IDLE;
                end
            end
            default: begin
                state_nxt = FL_ST_IDLE;
            end
        endcase
    end

    // A host write in the same cycle as the hardware return to standby wins,
    // because it carries the newer intent of software.
    assign mode_ctl_nxt = wr_mode    ? (reg_req.wdata & FL_MASK_MODE)
                        : hw_standby ? {mode_ctl_r[7:3], FL_MODE_STANDBY}
                        : mode_ctl_r;
    assign enable_nxt   = wr_enable  ? (reg_req.wdata & FL_MASK_ENABLE)
                        : hw_standby ? FL_RST_ENABLE
                        : enable_r;
    // A timeout that lands in the cycle of the clearing read stays set.
    assign fault_nxt    = (rd_fault ? FL_RST_FAULT : fault_r)
                        | (8'(timeout_fault) << FL_TIMEOUT_BIT);

    // Current codes survive mode changes, so a flash can follow assist without rewriting them.
    assign timer_nxt       = !en_pin ? FL_RST_TIMER : wr_timer ? (reg_req.wdata & FL_MASK_TIMER) : timer_r;
    assign led1_flash_nxt  = !en_pin ? FL_RST_LEVEL : wr_l1f ? reg_req.wdata : led1_flash_r;
    assign led1_assist_nxt = !en_pin ? FL_RST_LEVEL : wr_l1a ? reg_req.wdata : led1_assist_r;
    assign led2_flash_nxt  = !en_pin ? FL_RST_LEVEL : wr_l2f ? reg_req.wdata : led2_flash_r;
    assign led2_assist_nxt = !en_pin ? FL_RST_LEVEL : wr_l2a ? reg_req.wdata : led2_assist_r;

    // LED outputs are registered: they turn on one cycle after the state but go dark on the same edge that ends the flash, and never show decode glitches.
    // Every mode computes both outputs in full, so no output keeps a stale code between modes.
    always_comb begin
        led1_nxt = '0;
        led2_nxt = '0;
        case (operating_mode_field)
            FL_MODE_ASSIST, FL_MODE_TORCH5V: begin
                led1_nxt = led_pick(first_led_enable, 1'b1, led1_assist_r);
                led2_nxt = led_pick(second_led_enable, 1'b1, led2_assist_r);
            end
            FL_MODE_FLASH: begin
                led1_nxt = led_pick(first_led_enable, in_flash && !hw_standby, led1_flash_r);
                led2_nxt = led_pick(second_led_enable, in_flash && !hw_standby, led2_flash_r);
            end
            FL_MODE_INDEP_TO, FL_MODE_INDEP: begin
                led1_nxt = led_pick(indep_on1, !indep_timeout, led1_flash_r);
                led2_nxt = led_pick(indep_on2, !indep_timeout, led2_flash_r);
            end
            // Reserved mode 111 leaves both outputs dark, like standby.
            default: begin
                led1_nxt = '0;
                led2_nxt = '0;
            end
        endcase
    end

    // Hysteresis between the two comparator thresholds keeps the converter from chattering.
    wire        load_on  = led1_nxt.on || led2_nxt.on;
    wire        need_5v  = m_fixed5v || m_torch5v;
    always_comb begin
        boost_nxt = boost_r;
        if (need_5v) begin
            boost_nxt = 1'b1;
        end else if (!load_on) begin
            boost_nxt = 1'b0;
        end else if (headroom_short) begin
            boost_nxt = 1'b1;
        end else if (headroom_surplus) begin
            boost_nxt = 1'b0;
        end
    end

    // Unmapped offsets read as zero, so software can probe the map without side effects.
    assign rdata_nxt = (reg_req.addr == FL_OFS_MODE_CTL)    ? mode_ctl_r
                     : (reg_req.addr == FL_OFS_TIMER)       ? timer_r
                     : (reg_req.addr == FL_OFS_LED1_FLASH)  ? led1_flash_r
                     : (reg_req.addr == FL_OFS_LED1_ASSIST) ? led1_assist_r
                     : (reg_req.addr == FL_OFS_LED2_FLASH)  ? led2_flash_r
                     : (reg_req.addr == FL_OFS_LED2_ASSIST) ? led2_assist_r
                     : (reg_req.addr == FL_OFS_FAULT)       ? fault_r
                     : (reg_req.addr == FL_OFS_LED_ENABLE)  ? enable_r
                     : 8'h00;

    // Dropping the enable pin returns every register to its reset value.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ctl_r    <= FL_RST_MODE_CTL;
            timer_r       <= FL_RST_TIMER;
            led1_flash_r  <= FL_RST_LEVEL;
            led1_assist_r <= FL_RST_LEVEL;
            led2_flash_r  <= FL_RST_LEVEL;
            led2_assist_r <= FL_RST_LEVEL;
            fault_r       <= FL_RST_FAULT;
            enable_r      <= FL_RST_ENABLE;
        end else if (clk_en) begin
            mode_ctl_r    <= en_pin ? mode_ctl_nxt : FL_RST_MODE_CTL;
            timer_r       <= timer_nxt;
            led1_flash_r  <= led1_flash_nxt;
            led1_assist_r <= led1_assist_nxt;
            led2_flash_r  <= led2_flash_nxt;
            led2_assist_r <= led2_assist_nxt;
            fault_r       <= en_pin ? fault_nxt : FL_RST_FAULT;
            enable_r      <= en_pin ? enable_nxt : FL_RST_ENABLE;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r       <= FL_ST_IDLE;
            strobe_prev_r <= 1'b0;
            boost_r       <= 1'b0;
            led1_r        <= '0;
            led2_r        <= '0;
            reg_rdata     <= 8'h00;
        end else if (clk_en) begin
            // Losing the enable pin drops any flash at once and forgets an armed trigger.
            state_r       <= en_pin ? state_nxt : FL_ST_IDLE;
            strobe_prev_r <= strobe_act;
            boost_r       <= en_pin && boost_nxt;
            led1_r        <= en_pin ? led1_nxt : '0;
            led2_r        <= en_pin ? led2_nxt : '0;
            reg_rdata     <= rd_ok ? rdata_nxt : reg_rdata;
        end
    end

    assign led1_drive   = led1_r;
    assign led2_drive   = led2_r;
    assign boost_on     = boost_r;
    assign pass_through = (led1_r.on || led2_r.on) && !boost_r;
    assign vout_5v_reg  = need_5v;
    assign standby      = (operating_mode_field == FL_MODE_STANDBY);
    assign flash_active = (state_r == FL_ST_FLASH);

endmodule

// ===== verilog/fl_pkg.sv
package fl_pkg;

    // Register offsets on the serial register port.
    localparam logic [7:0] FL_OFS_MODE_CTL   = 8'h01;
    localparam logic [7:0] FL_OFS_TIMER      = 8'h02;
    localparam logic [7:0] FL_OFS_LED1_FLASH = 8'h06;
    localparam logic [7:0] FL_OFS_LED1_ASSIST = 8'h08;
    localparam logic [7:0] FL_OFS_LED2_FLASH = 8'h09;
    localparam logic [7:0] FL_OFS_LED2_ASSIST = 8'h0b;
    localparam logic [7:0] FL_OFS_FAULT      = 8'h0c;
    localparam logic [7:0] FL_OFS_LED_ENABLE = 8'h0f;

    // Field positions in the mode control register.
    localparam int FL_MODE_LSB      = 0;
    localparam int FL_MODE_MSB      = 2;
    localparam int FL_TRIG_SRC_BIT  = 3;
    localparam int FL_TRIG_POL_BIT  = 4;
    localparam int FL_TRIG_EDGE_BIT = 5;

    // Field positions in the timer, fault and enable registers.
    localparam int FL_TIMER_LSB     = 0;
    localparam int FL_TIMER_MSB     = 3;
    localparam int FL_TIMEOUT_BIT   = 4;
    localparam int FL_FIRST_LED_ENABLE_BIT   = 0;
    localparam int FL_SECOND_LED_ENABLE_BIT   = 1;

    // Reset values; writable bit masks of the control registers.
    localparam logic [7:0] FL_RST_MODE_CTL = 8'h00;
    localparam logic [7:0] FL_RST_TIMER    = 8'h0f;
    localparam logic [7:0] FL_RST_LEVEL    = 8'h00;
    localparam logic [7:0] FL_RST_FAULT    = 8'h00;
    localparam logic [7:0] FL_RST_ENABLE   = 8'h00;
    localparam logic [7:0] FL_MASK_MODE    = 8'h3f;
    localparam logic [7:0] FL_MASK_TIMER   = 8'h0f;
    localparam logic [7:0] FL_MASK_ENABLE  = 8'h03;

    // Flash duration: code n lasts (n + 1) steps, so code 15 gives the longest flash.
    localparam longint unsigned FL_CLK_HZ         = 64'd40_000_000;
    localparam longint unsigned FL_FLASH_MAX_MS   = 64'd1600;
    localparam longint unsigned FL_FLASH_STEPS    = 64'd16;
    localparam longint unsigned FL_FLASH_STEP_MS  = FL_FLASH_MAX_MS / FL_FLASH_STEPS;
    localparam int unsigned     FL_FLASH_STEP_CYCLES =
        32'(FL_FLASH_STEP_MS * FL_CLK_HZ / 64'd1000);

    typedef enum logic [2:0] {
        FL_MODE_STANDBY  = 3'h0,
        FL_MODE_FIXED5V  = 3'h1,
        FL_MODE_ASSIST   = 3'h2,
        FL_MODE_FLASH    = 3'h3,
        FL_MODE_INDEP_TO = 3'h4,
        FL_MODE_INDEP    = 3'h5,
        FL_MODE_TORCH5V  = 3'h6,
        FL_MODE_RESERVED = 3'h7
    } fl_mode_t;

    typedef enum logic [1:0] {
        FL_ST_IDLE  = 2'b00,
        FL_ST_ARMED = 2'b01,
        FL_ST_FLASH = 2'b11
    } fl_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fl_reg_req_t;

    typedef struct packed {
        logic       on;
        logic [7:0] level;
    } fl_led_drive_t;

endpackage
